/* verilog/sar_adc_sequencer.sv */
`timescale 1ns/10ps
module sar_adc_sequencer #(
  parameter int RES_W = sar_adc_pkg::RESULT_BITS,
  parameter int CHANS = sar_adc_pkg::CHAN_COUNT
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              general_timer_a,
  input  wire logic              general_timer_b,
  input  wire logic              general_timer_c,
  input  wire logic              pwm_timer_counter,
  input  wire logic              comparator_high,
  output logic      [CHANS-1:0]  channel_route,
  output logic      [RES_W-1:0]  dac_code,
  output logic                   sample_hold,
  output logic                   adc_irq
);

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_APPROX = 3'b100
  } seq_state_e;

  function automatic logic [CHANS-1:0] decode_channel(input logic [3:0] sel);
    logic [CHANS-1:0] onehot;
    onehot = '0;
    for (int i = 0; i < CHANS; i++) begin
      if (sel == 4'(i)) begin
        onehot[i] = 1'b1;
      end
    end
    return onehot;
  endfunction

  sar_adc_pkg::apb_req_s req;
  assign req = '{psel, penable, pwrite, paddr, pwdata};

  sar_adc_pkg::control_s ctl_reg, ctl_next;
  logic [5:0]       presc_reg, presc_next;
  logic [5:0]       div_cnt_reg, div_cnt_next;
  logic             tick;
  seq_state_e       state_reg, state_next;
  logic [4:0]       step_reg, step_next;
  logic [RES_W-1:0] approx_reg, approx_next;
  logic [RES_W-1:0] trial_reg, trial_next;
  logic [RES_W-1:0] result_reg, result_next;
  logic             done_reg, done_next;
  logic             stat_reg, stat_next;
  logic             mask_reg, mask_next;
  logic             sw_start_reg, sw_start_next;
  logic [3:0]       trig_prev_reg;
  logic [3:0]       trig_now;
  logic [3:0]       trig_rise;
  logic             complete;
  logic             wr_en;
  logic             rd_en;
  logic             addr_ok;
  logic [31:0]      prdata_next;
  logic [CHANS-1:0] route_next;
  logic [RES_W-1:0] dac_next;
  logic             hold_next;
  logic [5:0]       eff_div;
  logic             pready_next;
  logic             pslverr_next;
  logic             irq_next;

  assign wr_en = req.psel && req.penable && req.pwrite;
  assign rd_en = req.psel && !req.penable && !req.pwrite;
  assign addr_ok = (req.paddr == sar_adc_pkg::OFS_CONTROL) ||
                   (req.paddr == sar_adc_pkg::OFS_RESULT) ||
                   (req.paddr == sar_adc_pkg::OFS_PRESC) ||
                   (req.paddr == sar_adc_pkg::OFS_IRQ_STAT) ||
                   (req.paddr == sar_adc_pkg::OFS_IRQ_MASK);

  assign trig_now  = {pwm_timer_counter, general_timer_c, general_timer_b, general_timer_a};
  assign trig_rise = trig_now & ~trig_prev_reg & ctl_reg.trig_enable;

  // Divisor below the floor would overclock the converter, so it is clamped
  assign eff_div = (presc_reg < 6'(sar_adc_pkg::MIN_DIV)) ? 6'(sar_adc_pkg::MIN_DIV)
                                                           : presc_reg;

  // Prescaler: one tick every eff_div peripheral clocks
  always_comb begin
    tick = (div_cnt_reg >= eff_div - 6'h01);
    div_cnt_next = tick ? 6'h00 : div_cnt_reg + 6'h01;
  end

  assign complete = tick && (state_reg == ST_APPROX) &&
                    (step_reg == 5'(sar_adc_pkg::CONV_CLOCKS - 1));

  // Register file and flags
  always_comb begin
    ctl_next      = ctl_reg;
    presc_next    = presc_reg;
    mask_next     = mask_reg;
    stat_next     = stat_reg;
    done_next     = done_reg;
    sw_start_next = sw_start_reg;
    // Consuming a pending start comes first, so a start written in the same
    // cycle survives and runs after this conversion
    if (state_reg == ST_IDLE && (sw_start_reg || |trig_rise)) begin
      sw_start_next = 1'b0;
      done_next     = 1'b0;
    end
    if (wr_en) begin
      case (req.paddr)
        sar_adc_pkg::OFS_CONTROL: begin
          ctl_next.channel     = req.pwdata[sar_adc_pkg::CTL_CHAN_LSB +: 4];
          ctl_next.trig_enable = req.pwdata[sar_adc_pkg::CTL_TRIG_LSB +: 4];
          if (req.pwdata[sar_adc_pkg::CTL_START_BIT]) begin
            sw_start_next = 1'b1;
          end
        end
        sar_adc_pkg::OFS_PRESC:    presc_next = req.pwdata[5:0];
        sar_adc_pkg::OFS_IRQ_STAT: begin
          if (req.pwdata[0]) begin
            stat_next = 1'b0;
          end
        end
        sar_adc_pkg::OFS_IRQ_MASK: mask_next = req.pwdata[0];
        default: ;
      endcase
    end
    // Completion wins over a same-cycle clear
    if (complete) begin
      done_next = 1'b1;
      stat_next = 1'b1;
    end
  end

  // Conversion sequencer: sampling clocks, then one bit per converter clock
  always_comb begin
    state_next  = state_reg;
    step_next   = step_reg;
    approx_next = approx_reg;
    trial_next  = trial_reg;
    result_next = result_reg;
    case (state_reg)
      ST_IDLE: begin
        if (sw_start_reg || |trig_rise) begin
          state_next  = ST_SAMPLE;
          step_next   = 5'h00;
          approx_next = '0;
          trial_next  = {1'b1, {(RES_W-1){1'b0}}};
        end
      end
      ST_SAMPLE: begin
        if (tick) begin
          step_next = step_reg + 5'h01;
          if (step_reg == 5'(sar_adc_pkg::SAMPLE_CLOCKS - 1)) begin
            state_next = ST_APPROX;
          end
        end
      end
      ST_APPROX: begin
        if (tick) begin
          step_next = step_reg + 5'h01;
          if (comparator_high) begin
            approx_next = approx_reg | trial_reg;
          end
          trial_next = trial_reg >> 1;
          // Last tick folds the final comparator decision into the result
          if (complete) begin
            result_next = comparator_high ? (approx_reg | trial_reg) : approx_reg;
            state_next  = ST_IDLE;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Analog-side drives and bus read data
  always_comb begin
    route_next = decode_channel(ctl_reg.channel);
    hold_next  = (state_next == ST_SAMPLE);
    dac_next   = approx_next | trial_next;
    // Trial code rests at zero while idle
    if (state_next == ST_IDLE) begin
      dac_next = '0;
    end
    prdata_next = prdata;
    if (rd_en) begin
      case (req.paddr)
        sar_adc_pkg::OFS_CONTROL: begin
          prdata_next = '0;
          prdata_next[sar_adc_pkg::CTL_CHAN_LSB +: 4] = ctl_reg.channel;
          prdata_next[sar_adc_pkg::CTL_TRIG_LSB +: 4] = ctl_reg.trig_enable;
          prdata_next[sar_adc_pkg::CTL_DONE_BIT]      = done_reg;
          prdata_next[sar_adc_pkg::CTL_BUSY_BIT]      = (state_reg != ST_IDLE);
        end
        sar_adc_pkg::OFS_RESULT:   prdata_next = {20'h00000, result_reg};
        sar_adc_pkg::OFS_PRESC:    prdata_next = {26'h0000000, presc_reg};
        sar_adc_pkg::OFS_IRQ_STAT: prdata_next = {31'h00000000, stat_reg};
        sar_adc_pkg::OFS_IRQ_MASK: prdata_next = {31'h00000000, mask_reg};
        default:                   prdata_next = 32'h00000000;
      endcase
    end
  end

  // Handshake and interrupt level, registered with the other outputs
  always_comb begin
    // Zero wait states: ready answers every setup cycle one clock later
    pready_next  = req.psel && !req.penable;
    pslverr_next = req.psel && !req.penable && !addr_ok;
    irq_next     = stat_next && mask_next;
  end

  // Prescaler counter runs free, so the first tick after a start may come early
  always_ff @(posedge clk) begin
    if (rst) begin
      div_cnt_reg <= 6'h00;
    end else begin
      div_cnt_reg <= div_cnt_next;
    end
  end

  // Trigger history for edge detection; the pins idle low
  always_ff @(posedge clk) begin
    if (rst) begin
      trig_prev_reg <= 4'h0;
    end else begin
      trig_prev_reg <= trig_now;
    end
  end

  // Register file and flags
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_reg      <= '{sar_adc_pkg::CHAN_RESET, sar_adc_pkg::TRIG_RESET};
      presc_reg    <= sar_adc_pkg::PRESC_RESET;
      mask_reg     <= sar_adc_pkg::MASK_RESET;
      stat_reg     <= 1'b0;
      done_reg     <= 1'b0;
      sw_start_reg <= 1'b0;
    end else begin
      ctl_reg      <= ctl_next;
      presc_reg    <= presc_next;
      mask_reg     <= mask_next;
      stat_reg     <= stat_next;
      done_reg     <= done_next;
      sw_start_reg <= sw_start_next;
    end
  end

  // Conversion sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg  <= ST_IDLE;
      step_reg   <= 5'h00;
      approx_reg <= '0;
      trial_reg  <= '0;
      result_reg <= sar_adc_pkg::RESULT_RESET;
    end else begin
      state_reg  <= state_next;
      step_reg   <= step_next;
      approx_reg <= approx_next;
      trial_reg  <= trial_next;
      result_reg <= result_next;
    end
  end

  // Registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata        <= 32'h00000000;
      pready        <= 1'b0;
      pslverr       <= 1'b0;
      channel_route <= '0;
      dac_code      <= '0;
      sample_hold   <= 1'b0;
      adc_irq       <= 1'b0;
    end else begin
      prdata        <= prdata_next;
      pready        <= pready_next;
      pslverr       <= pslverr_next;
      channel_route <= route_next;
      dac_code      <= dac_next;
      sample_hold   <= hold_next;
      adc_irq       <= irq_next;
    end
  end

endmodule // sar_adc_sequencer

/* verilog/sar_adc_pkg.sv */
package sar_adc_pkg;
  localparam int RESULT_BITS  = 12;
  localparam int CHAN_COUNT   = 14;
  localparam int PRESC_BITS   = 6;
  localparam int CONV_CLOCKS  = 30;
  localparam int SAMPLE_CLOCKS = CONV_CLOCKS - RESULT_BITS;

  // Converter clock ceiling and the peripheral clock rate
  localparam int MAX_CONV_KHZ = 4500;
  localparam int PCLK_KHZ     = 125000;
  // Smallest divisor that keeps the converter clock at or below its ceiling
  localparam int MIN_DIV      = (PCLK_KHZ + MAX_CONV_KHZ - 1) / MAX_CONV_KHZ;

  // Byte offsets
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_RESULT   = 8'h04;
  localparam logic [7:0] OFS_PRESC    = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

  // Control register fields
  localparam int CTL_CHAN_LSB  = 0;
  localparam int CTL_START_BIT = 4;
  localparam int CTL_TRIG_LSB  = 8;
  localparam int CTL_DONE_BIT  = 12;
  localparam int CTL_BUSY_BIT  = 13;

  localparam logic [3:0]  CHAN_RESET  = 4'h0;
  localparam logic [3:0]  TRIG_RESET  = 4'h0;
  localparam logic [5:0]  PRESC_RESET = 6'h1f;
  localparam logic [11:0] RESULT_RESET = 12'h000;
  localparam logic        MASK_RESET  = 1'b0;

  typedef struct packed {
    logic [3:0] channel;
    logic [3:0] trig_enable;
  } control_s;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_s;
endpackage

/* tb/sar_adc_sequencer_properties.sv */
`timescale 1ns/10ps
module sar_adc_sequencer_properties #(
  parameter int CHANS = sar_adc_pkg::CHAN_COUNT
) (
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  input wire logic [CHANS-1:0] channel_route,
  input wire logic             adc_irq
);
  logic mapped;
  assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_setup; psel && !penable; endsequence
  sequence s_take; psel && penable && pready; endsequence
  a_ready_setup: assert property (s_setup |=> pready) else $error("pready late");
  a_ready_access: assert property (pready |-> psel && penable) else $error("stray pready");
  a_err_ready: assert property (pslverr |-> pready) else $error("stray pslverr");
  a_err_unmapped: assert property (s_setup ##0 !mapped
    |=> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped not refused");
  a_ok_mapped: assert property (s_setup ##0 mapped |=> !pslverr) else $error("mapped refused");
  a_route_onehot: assert property ($onehot0(channel_route)) else $error("two inputs routed");
  a_ctl_read_bits: assert property (s_setup ##0 (!pwrite && paddr == 8'h00)
    |=> !prdata[4] && !(prdata[12] && prdata[13])) else $error("control read bits");
  a_mask_irq_off: assert property (s_take ##0 (pwrite && paddr == 8'h10 && !pwdata[0])
    |=> ##1 !adc_irq) else $error("masked irq high");
endmodule // sar_adc_sequencer_properties
bind sar_adc_sequencer sar_adc_sequencer_properties #(.CHANS(CHANS)) chk (.clk(clk),
  .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .channel_route(channel_route), .adc_irq(adc_irq));

/* tb/analog_front_model.sv */
`timescale 1ns/10ps
module analog_front_model #(
  parameter int CHANS = 14
) (
  input wire logic [CHANS-1:0]    channel_route,
  input wire logic [11:0]         dac_code,
  input wire logic [CHANS*12-1:0] levels,
  output logic                    comparator_high
);
  // Nothing routed: answer flips with the code, so no stale level is seen
  always_comb begin
    comparator_high = ^dac_code;
    for (int i = 0; i < CHANS; i++) begin
      if (channel_route[i]) begin
        comparator_high = levels[i*12 +: 12] >= dac_code;
      end
    end
  end
endmodule // analog_front_model

/* tb/sar_adc_sequencer_bench.sv */
`timescale 1ns/10ps
module sar_adc_sequencer_bench;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        pready, pslverr, sample_hold, adc_irq, cmp, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [3:0]  trig = 4'h0, ch;
  logic [13:0] channel_route;
  logic [11:0] dac_code, val;
  logic [5:0]  p;
  logic [167:0] levels = '0;
  int          n_fail = 0, n_tests = 0, cyc = 0, t0, div;
  always #4 clk = ~clk;
  sar_adc_sequencer uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .general_timer_a(trig[0]), .general_timer_b(trig[1]),
    .general_timer_c(trig[2]), .pwm_timer_counter(trig[3]), .comparator_high(cmp),
    .channel_route(channel_route), .dac_code(dac_code), .sample_hold(sample_hold),
    .adc_irq(adc_irq));
  analog_front_model afe (.channel_route(channel_route), .dac_code(dac_code),
    .levels(levels), .comparator_high(cmp));
  task test_done;
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Start by software bit (how 0) or by enabling trigger how-1
  function logic [31:0] ctl_word(input logic [3:0] c, input int how);
    return (how == 0) ? {27'h0, 1'b1, c} : ((32'h1 << (7 + how)) | {28'h0, c});
  endfunction
  // Converter tick phase is free, so allow one tick either side
  function logic lat_ok(input int d, input int n);
    return n >= 29 * d && n <= 31 * d + 8;
  endfunction
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      test_done;
    end
  end
  initial begin
    void'($urandom(4));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, sar_adc_pkg::OFS_PRESC, 32'h0);
    chk("presc_reset", 32'h1f, q);
    apb(1'b0, sar_adc_pkg::OFS_RESULT, 32'h0);
    chk("result_reset", 32'h0, q);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped_err", 32'h1, 32'(err));
    apb(1'b1, sar_adc_pkg::OFS_IRQ_MASK, 32'h1);
    for (int i = 0; i < 5; i++) begin
      ch = 4'($urandom_range(13));
      val = (i == 1) ? 12'hfff : (i == 2) ? 12'h000 : 12'($urandom);
      p = (i == 0) ? 6'h00 : (i < 3) ? 6'h1c : 6'($urandom_range(63));
      div = (p < 28) ? 28 : int'(p);
      levels[ch*12 +: 12] = val;
      apb(1'b1, sar_adc_pkg::OFS_PRESC, 32'(p));
      apb(1'b0, sar_adc_pkg::OFS_PRESC, 32'h0);
      chk("presc", 32'(p), q);
      apb(1'b1, sar_adc_pkg::OFS_CONTROL, ctl_word(ch, i));
      t0 = cyc;
      if (i > 0) begin
        trig[i-1] <= 1'b1;
        @(posedge clk);
        trig <= 4'h0;
        t0 = cyc;
      end
      repeat (4) @(posedge clk);
      chk("route", 32'(14'h1 << ch), 32'(channel_route));
      chk("hold", 32'h1, 32'(sample_hold));
      apb(1'b0, sar_adc_pkg::OFS_CONTROL, 32'h0);
      chk("busy_done", 32'h2, 32'(q[13:12]));
      while (adc_irq !== 1'b1) @(posedge clk);
      chk("latency", 32'h1, 32'(lat_ok(div, cyc - t0)));
      chk("hold_end", 32'h0, 32'(sample_hold));
      chk("dac_idle", 32'h0, 32'(dac_code));
      apb(1'b0, sar_adc_pkg::OFS_RESULT, 32'h0);
      chk("result", 32'(val), q);
      levels[ch*12 +: 12] = ~val;
      apb(1'b0, sar_adc_pkg::OFS_RESULT, 32'h0);
      chk("result_hold", 32'(val), q);
      apb(1'b0, sar_adc_pkg::OFS_CONTROL, 32'h0);
      chk("done", 32'h1, 32'(q[12]));
      if (i == 4) begin
        apb(1'b1, sar_adc_pkg::OFS_IRQ_MASK, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq_masked", 32'h0, 32'(adc_irq));
        apb(1'b1, sar_adc_pkg::OFS_IRQ_MASK, 32'h1);
        repeat (2) @(posedge clk);
      end
      chk("irq", 32'h1, 32'(adc_irq));
      apb(1'b1, sar_adc_pkg::OFS_IRQ_STAT, 32'h1);
      repeat (2) @(posedge clk);
      chk("irq_clear", 32'h0, 32'(adc_irq));
    end
    test_done;
  end
endmodule // sar_adc_sequencer_bench
